// ==== core/tit_pkg.sv ====
// Constants and types for the thread interrupt targeting block
// Summary of operation
// (RQ1) Any fp exception mode bit in either thread forces single issue.
// (RQ2) Single issue holds both threads at issue during execute.
// (RQ3) Other interrupt types go only to the causing thread.
// (RQ4) Target thread follows exception and interrupt type.
// (RQ5) Active target takes it; suspended target wakes per policy.
// (RQ6) Reset starts thread 0 only, reason 101.
// (RQ7) Run bit write resumes that thread, reason 101.
// (RQ8) Machine check hits active threads, mc enable mask, no wake.
// (RQ9) External direct or mediated by config bit, programmable target.
// (RQ10) Wake on external wakes a suspended target, reason 100.
// (RQ11) Decrementer to own thread, external enable mask, wake 011.
// (RQ12) System error to active threads, not hypervisor, wake 110.
// (RQ13) Thermal to active threads, thermal enable mask, wake 010.
// (RQ14) Instruction maintenance to causer; trace maintenance to all (code: only threads with external enable set and not hypervisor).
// (RQ15) Synchronous faults go only to the causer and never wake.
// (RQ16) Hypervisor decrementer to active threads, never wakes.
// (RQ17) Every resume sets the thread priority to high, 11.
// (RQ18) A waking interrupt stays pending until the thread unmasks it.
package tit_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // ************************************************
    // Register offsets
    // ************************************************
    localparam logic [7:0] OFF_RUN    = 8'h00;
    localparam logic [7:0] OFF_WAKE   = 8'h04;
    localparam logic [7:0] OFF_CFG    = 8'h08;
    localparam logic [7:0] OFF_REASON = 8'h0c;
    localparam logic [7:0] OFF_PRIO   = 8'h10;
    localparam logic [7:0] OFF_STAT   = 8'h14;
    localparam logic [7:0] OFF_MASK   = 8'h18;
    // Wake config field positions
    localparam int WK_EXT   = 0;
    localparam int WK_DEC0  = 1;
    localparam int WK_THERM = 3;
    localparam int WK_SYSER = 4;
    // Interrupt config field positions
    localparam int CF_HSRR  = 0;
    localparam int CF_MCHK  = 1;
    localparam int CF_TINT  = 2;
    localparam int CF_PENV  = 3;
    localparam int CF_MED   = 4;
    localparam int CF_HDEN  = 5;
    localparam int CF_TGT   = 6;
    // Status bits
    localparam int ST_RES0  = 0;
    localparam int ST_RES1  = 1;
    localparam int ST_SNGL  = 2;
    localparam int ST_W     = 3;
    // ************************************************
    // Reset values and codes
    // ************************************************
    localparam logic [1:0] RUN_RST   = 2'h1;
    localparam logic [4:0] WAKE_RST  = 5'h00;
    localparam logic [7:0] CFG_RST   = 8'h40;
    localparam logic [1:0] PRIO_HIGH = 2'h3;
    localparam logic [1:0] PRIO_RST  = 2'h2;
    localparam logic [2:0] RSN_SYSRST = 3'h5;
    localparam logic [2:0] RSN_THERM  = 3'h2;
    localparam logic [2:0] RSN_SYSERR = 3'h6;
    localparam logic [2:0] RSN_EXT    = 3'h4;
    localparam logic [2:0] RSN_DEC    = 3'h3;
    localparam int SYNC_W = 4;
    localparam int NSRC   = 8;

    typedef enum logic [4:0] {
        INT_NONE    = 5'h00,
        INT_DSTOR   = 5'h01,
        INT_DSEG    = 5'h02,
        INT_ISTOR   = 5'h03,
        INT_ISEG    = 5'h04,
        INT_ALIGN   = 5'h05,
        INT_PROG    = 5'h06,
        INT_FPU     = 5'h07,
        INT_SC      = 5'h08,
        INT_TRACE   = 5'h09,
        INT_VMU     = 5'h0a,
        INT_MAINT_I = 5'h0b,
        INT_MC      = 5'h10,
        INT_SYSERR  = 5'h11,
        INT_MAINT_S = 5'h12,
        INT_THERM   = 5'h13,
        INT_HDEC    = 5'h14,
        INT_EXT     = 5'h15,
        INT_DEC     = 5'h16
    } tit_int_t;
endpackage : tit_pkg

// ==== core/tit_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module tit_pin_sync #(
    parameter int W = 4
) (
    input  wire logic         mclk_i,
    input  wire logic         sys_rst_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);
    logic [W-1:0] ff1_reg;
    logic [W-1:0] ff2_reg;
    logic [W-1:0] ff3_reg;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ff1_reg <= '0;
            ff2_reg <= '0;
            ff3_reg <= '0;
        end else begin
            ff1_reg <= pin_i;
            ff2_reg <= ff1_reg;
            ff3_reg <= ff2_reg;
        end
    end

    // A bit moves only once two late stages agree
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge mclk_i) begin
                if (sys_rst_i) begin
                    level_o[i] <= 1'b0;
                end else if (ff2_reg[i] == ff3_reg[i]) begin
                    level_o[i] <= ff3_reg[i];
                end
            end
        end
    endgenerate
endmodule : tit_pin_sync

// ==== core/tit_core.sv ====
// Interrupt targeting, wake and single-issue control for two threads
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
module tit_core (
    input  wire logic              mclk_i,
    input  wire logic              sys_rst_i,
    // Register port
    input  wire logic [7:0]        addr_i,
    input  wire logic [31:0]       wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [31:0]       rdata_o,
    // Machine state of each thread
    input  wire logic [1:0]        fp_exc_mode_0_i,
    input  wire logic [1:0]        fp_exc_mode_1_i,
    input  wire logic [1:0]        external_enable_i,
    input  wire logic [1:0]        hypervisor_state_i,
    input  wire logic [1:0]        user_privilege_state_i,
    input  wire logic [1:0]        supervisor_bit_i,
    input  wire logic [1:0]        mc_enable_i,
    // Core-side events
    input  wire logic              exc_valid_i,
    input  wire logic              exc_thread_i,
    input  wire tit_pkg::tit_int_t exc_kind_i,
    input  wire logic              mc_int_i,
    input  wire logic [1:0]        dec_int_i,
    input  wire logic              hdec_int_i,
    input  wire logic [1:0]        suspend_i,
    input  wire logic              exec_busy_i,
    // Pins from outside the core
    input  wire logic              ext_int_pin_i,
    input  wire logic              sys_mc_pin_i,
    input  wire logic              therm_pin_i,
    input  wire logic              trace_sig_pin_i,
    // Thread control
    output logic      [1:0]        thread_active_o,
    output logic      [1:0]        resume_o,
    output logic      [1:0]        int_req_o,
    output tit_pkg::tit_int_t      int_code0_o,
    output tit_pkg::tit_int_t      int_code1_o,
    output logic      [2:0]        reason0_o,
    output logic      [2:0]        reason1_o,
    output logic      [1:0]        prio0_o,
    output logic      [1:0]        prio1_o,
    output logic                   single_issue_o,
    output logic      [1:0]        issue_hold_o,
    output logic                   irq_o
);
    // ************************************************
    // Registers and pin levels
    // ************************************************
    localparam int NSRC_L = tit_pkg::NSRC;
    logic [4:0]        wake_reg;
    logic [7:0]        cfg_reg;
    logic [2:0]        stat_reg;
    logic [2:0]        mask_reg;
    logic [3:0]        pin_lvl;
    logic [1:0]        sw_run;
    logic [1:0]        wake;
    logic [2:0]        rsn  [2];
    logic [NSRC_L-1:0] req  [2];
    tit_pkg::tit_int_t code [2];
    logic              ext_pend;
    logic              sys_pend;
    logic              fp_any;

    tit_pin_sync #(
        .W(tit_pkg::SYNC_W)
    ) u_sync (
        .mclk_i   (mclk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i    ({trace_sig_pin_i, therm_pin_i, sys_mc_pin_i,
                    ext_int_pin_i}),
        .level_o  (pin_lvl)
    );

    function automatic logic wr_hit(input logic [7:0] off);
        wr_hit = wr_i && (addr_i == off);
    endfunction : wr_hit

    // Fixed priority pick; precise faults first since they are one-shot
    function automatic tit_pkg::tit_int_t pick(
        input logic [NSRC_L-1:0] r,
        input tit_pkg::tit_int_t sync_kind
    );
        if (r[0]) pick = sync_kind;
        else if (r[1]) pick = tit_pkg::INT_MC;
        else if (r[2]) pick = tit_pkg::INT_SYSERR;
        else if (r[3]) pick = tit_pkg::INT_MAINT_S;
        else if (r[4]) pick = tit_pkg::INT_THERM;
        else if (r[5]) pick = tit_pkg::INT_HDEC;
        else if (r[6]) pick = tit_pkg::INT_EXT;
        else if (r[7]) pick = tit_pkg::INT_DEC;
        else pick = tit_pkg::INT_NONE;
    endfunction : pick

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wake_reg <= tit_pkg::WAKE_RST;
        end else if (wr_hit(tit_pkg::OFF_WAKE)) begin
            wake_reg <= wdata_i[4:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cfg_reg <= tit_pkg::CFG_RST;
        end else if (wr_hit(tit_pkg::OFF_CFG)) begin
            cfg_reg <= wdata_i[7:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            mask_reg <= '0;
        end else if (wr_hit(tit_pkg::OFF_MASK)) begin
            mask_reg <= wdata_i[2:0];
        end
    end

    assign sw_run = wr_hit(tit_pkg::OFF_RUN) ? wdata_i[1:0] : 2'h0;

    // ************************************************
    // Single-issue mode
    // ************************************************
    assign fp_any = |{fp_exc_mode_0_i, fp_exc_mode_1_i};

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            single_issue_o <= 1'b0;
        end else begin
            single_issue_o <= fp_any; // RQ1
        end
    end

    // Issue is held only while the lone instruction is still executing
    assign issue_hold_o = {2{single_issue_o & exec_busy_i}}; // RQ2

    // ************************************************
    // Source pending and masking
    // ************************************************
    // Mediated request counts as external pending even with the pin low
    assign ext_pend = pin_lvl[0] |
                      (cfg_reg[tit_pkg::CF_HSRR] & cfg_reg[tit_pkg::CF_MED]);
    assign sys_pend = pin_lvl[1] & cfg_reg[tit_pkg::CF_MCHK]; // RQ12

    genvar t;
    generate
        for (t = 0; t < 2; t++) begin : g_thr
            logic en, hyp, ext_ok, tgt;
            assign en  = external_enable_i[t];
            assign hyp = hypervisor_state_i[t];
            assign tgt = cfg_reg[tit_pkg::CF_TGT + t];
            always_comb begin
                ext_ok = 1'b0;
                if (!cfg_reg[tit_pkg::CF_HSRR]) begin
                    ext_ok = pin_lvl[0] & en; // RQ9
                end else begin
                    if (pin_lvl[0] && (en ||
                        (!cfg_reg[tit_pkg::CF_PENV] && !hyp) ||
                        supervisor_bit_i[t])) begin
                        ext_ok = 1'b1; // RQ9
                    end
                    if (cfg_reg[tit_pkg::CF_MED] && en &&
                        (!hyp || user_privilege_state_i[t])) begin
                        ext_ok = 1'b1; // RQ9
                    end
                end
            end

            // Requests only reach a thread that is running
            assign req[t][0] = exc_valid_i && (exc_thread_i == t); // RQ3 RQ15
            assign req[t][1] = mc_int_i & mc_enable_i[t]; // RQ8
            assign req[t][2] = sys_pend & en & !hyp; // RQ12
            assign req[t][3] = pin_lvl[3] & en & !hyp; // RQ14
            assign req[t][4] = pin_lvl[2] & cfg_reg[tit_pkg::CF_TINT]; // RQ13
            assign req[t][5] = hdec_int_i & // RQ16
                               (en | (!hyp & cfg_reg[tit_pkg::CF_HDEN]));
            assign req[t][6] = ext_ok & tgt; // RQ9
            assign req[t][7] = dec_int_i[t] & en; // RQ11
            assign code[t]   = pick(req[t], exc_kind_i); // RQ4

            // Wake sources ignore the machine state mask on purpose
            always_comb begin
                wake[t] = 1'b1;
                rsn[t]  = tit_pkg::RSN_SYSRST;
                if (sw_run[t]) begin
                    rsn[t] = tit_pkg::RSN_SYSRST; // RQ7
                end else if (ext_pend && tgt && wake_reg[tit_pkg::WK_EXT]) begin
                    rsn[t] = tit_pkg::RSN_EXT; // RQ10
                end else if (dec_int_i[t] && wake_reg[tit_pkg::WK_DEC0 + t]) begin
                    rsn[t] = tit_pkg::RSN_DEC; // RQ11
                end else if (sys_pend && wake_reg[tit_pkg::WK_SYSER]) begin
                    rsn[t] = tit_pkg::RSN_SYSERR; // RQ12
                end else if (pin_lvl[2] && wake_reg[tit_pkg::WK_THERM]) begin
                    rsn[t] = tit_pkg::RSN_THERM; // RQ13
                end else begin
                    wake[t] = 1'b0; // RQ8 RQ16
                end
            end

            // Thread run state; a suspend in the same cycle as a wake still stops an active thread
            always_ff @(posedge mclk_i) begin
                if (sys_rst_i) begin
                    thread_active_o[t] <= tit_pkg::RUN_RST[t]; // RQ6
                    resume_o[t]        <= 1'b0;
                end else if (!thread_active_o[t] && wake[t]) begin
                    thread_active_o[t] <= 1'b1; // RQ5
                    resume_o[t]        <= 1'b1;
                end else begin
                    thread_active_o[t] <= thread_active_o[t] & !suspend_i[t];
                    resume_o[t]        <= 1'b0;
                end
            end

            // A woken thread still needs its own mask open to take it
            always_ff @(posedge mclk_i) begin
                if (sys_rst_i) begin
                    int_req_o[t] <= 1'b0;
                end else begin
                    int_req_o[t] <= thread_active_o[t] &&
                                    (code[t] != tit_pkg::INT_NONE); // RQ5 RQ18
                end
            end
        end
    endgenerate

    // ************************************************
    // Delivered codes, reason codes and priority
    // ************************************************
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            int_code0_o <= tit_pkg::INT_NONE;
            int_code1_o <= tit_pkg::INT_NONE;
        end else begin
            int_code0_o <= thread_active_o[0] ? code[0] : tit_pkg::INT_NONE;
            int_code1_o <= thread_active_o[1] ? code[1] : tit_pkg::INT_NONE;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            reason0_o <= tit_pkg::RSN_SYSRST; // RQ6
            reason1_o <= 3'h0;
        end else begin
            if (!thread_active_o[0] && wake[0]) begin
                reason0_o <= rsn[0];
            end
            if (!thread_active_o[1] && wake[1]) begin
                reason1_o <= rsn[1];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            prio0_o <= tit_pkg::PRIO_RST;
            prio1_o <= tit_pkg::PRIO_RST;
        end else begin
            if (!thread_active_o[0] && wake[0]) begin
                prio0_o <= tit_pkg::PRIO_HIGH; // RQ17
            end else if (wr_hit(tit_pkg::OFF_PRIO)) begin
                prio0_o <= wdata_i[1:0];
            end
            if (!thread_active_o[1] && wake[1]) begin
                prio1_o <= tit_pkg::PRIO_HIGH; // RQ17
            end else if (wr_hit(tit_pkg::OFF_PRIO)) begin
                prio1_o <= wdata_i[3:2];
            end
        end
    end

    // ************************************************
    // Status, interrupt and read port
    // ************************************************
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            stat_reg <= '0;
        end else begin
            // A new event in the clearing cycle survives the clear
            stat_reg <= (stat_reg & ~(wr_hit(tit_pkg::OFF_STAT) ?
                         wdata_i[2:0] : 3'h0)) |
                        {fp_any & !single_issue_o, resume_o[1], resume_o[0]};
        end
    end

    assign irq_o = |(stat_reg & mask_reg);

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rdata_o <= 32'h0;
        end else if (rd_i) begin
            case (addr_i)
                tit_pkg::OFF_RUN:    rdata_o <= {30'h0, thread_active_o};
                tit_pkg::OFF_WAKE:   rdata_o <= {27'h0, wake_reg};
                tit_pkg::OFF_CFG:    rdata_o <= {24'h0, cfg_reg};
                tit_pkg::OFF_REASON: rdata_o <= {26'h0, reason1_o, reason0_o};
                tit_pkg::OFF_PRIO:   rdata_o <= {28'h0, prio1_o, prio0_o};
                tit_pkg::OFF_STAT:   rdata_o <= {29'h0, stat_reg};
                tit_pkg::OFF_MASK:   rdata_o <= {29'h0, mask_reg};
                default:             rdata_o <= 32'h0;
            endcase
        end else begin
            rdata_o <= 32'h0;
        end
    end

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    property p_fp_single;
        fp_any |=> single_issue_o ##1 (single_issue_o || !$past(fp_any));
    endproperty
    a_fp_single: assert property (p_fp_single) // RQ1
        else $error("single issue not entered");

    property p_hold;
        single_issue_o && exec_busy_i |-> issue_hold_o == 2'h3;
    endproperty
    a_hold: assert property (p_hold) // RQ2
        else $error("issue not held in single issue");

    property p_por;
        $fell(sys_rst_i) |-> thread_active_o == 2'h1 &&
            reason0_o == 3'h5;
    endproperty
    a_por: assert property (p_por) // RQ6
        else $error("reset did not start thread 0 only");

    property p_sw_run;
        wr_i && addr_i == 8'h00 && wdata_i[1] && !thread_active_o[1]
        |=> thread_active_o[1] && resume_o[1] && reason1_o == 3'h5;
    endproperty
    a_sw_run: assert property (p_sw_run) // RQ7
        else $error("software resume failed");

    property p_req_active;
        int_req_o[1] |-> $past(thread_active_o[1]);
    endproperty
    a_req_active: assert property (p_req_active) // RQ5
        else $error("interrupt sent to suspended thread");

    property p_sync_own;
        exc_valid_i && !exc_thread_i && thread_active_o[0]
        |=> int_req_o[0] && int_code0_o == $past(exc_kind_i);
    endproperty
    a_sync_own: assert property (p_sync_own) // RQ15
        else $error("precise fault not delivered to causer");

    property p_dec_wake;
        dec_int_i[1] && wake_reg[2] && !thread_active_o[1]
        |=> thread_active_o[1] ##1 thread_active_o[1] || $past(suspend_i[1]);
    endproperty
    a_dec_wake: assert property (p_dec_wake) // RQ11
        else $error("decrementer did not wake thread 1");

    property p_prio;
        $rose(thread_active_o[0]) |-> prio0_o == 2'h3;
    endproperty
    a_prio: assert property (p_prio) // RQ17
        else $error("resume left priority low");

    c_wake_ext: cover property (resume_o[1] && reason1_o == 3'h4);
    c_single: cover property (single_issue_o && exec_busy_i);
    c_mc_both: cover property (int_req_o == 2'h3 && int_code0_o ==
                               tit_pkg::INT_MC);
    c_irq: cover property ($rose(irq_o));
endmodule : tit_core

// ==== testbench/tit_thread_model.sv ====
// Behavioural model of the two threads' interrupt enable state
`timescale 1ns/1ns
module tit_thread_model (
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [1:0] resume_i,
    input  wire logic [1:0] ld_i,
    input  wire logic [1:0] en_i,
    input  wire logic [1:0] hs_i,
    output logic      [1:0] en_o,
    output logic      [1:0] hs_o
);
    // Entry at the reset vector masks the waking interrupt again
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            en_o <= 2'h0;
            hs_o <= 2'h3;
        end else begin
            for (int t = 0; t < 2; t++) begin
                if (resume_i[t]) begin
                    en_o[t] <= 1'b0;
                    hs_o[t] <= 1'b1;
                end else if (ld_i[t]) begin
                    en_o[t] <= en_i[t];
                    hs_o[t] <= hs_i[t];
                end
            end
        end
    end
endmodule : tit_thread_model

// ==== testbench/tb.sv ====
// Self-checking bench for the thread interrupt targeting block
`timescale 1ns/1ns
module tb;
    logic mclk_i = 0, sys_rst_i = 1, wr_i, rd_i, irq_o, single_issue_o;
    logic [7:0] addr_i;
    logic [31:0] wdata_i, rdata_o;
    logic [1:0] fp0, fp1, mce, dec_int_i, suspend_i, ld, en_in, hs_in, en, hs;
    logic exc_valid_i, exc_thread_i, mc_int_i, hdec_int_i, exec_busy_i;
    logic ext_int_pin_i, sys_mc_pin_i, therm_pin_i, trace_sig_pin_i;
    logic [1:0] thread_active_o, resume_o, int_req_o, issue_hold_o;
    logic [1:0] prio0_o, prio1_o;
    logic [2:0] reason0_o, reason1_o;
    tit_pkg::tit_int_t exc_kind_i, int_code0_o, int_code1_o;
    int n_mismatch = 0, n_compared = 0, seed = 6, r, t;
    int m_act[2], m_rsn[2], m_prio[2];
    int wbit[$] = '{tit_pkg::WK_EXT, tit_pkg::WK_DEC0 + 1,
                    tit_pkg::WK_SYSER, tit_pkg::WK_THERM};
    int wrsn[$] = '{tit_pkg::RSN_EXT, tit_pkg::RSN_DEC,
                    tit_pkg::RSN_SYSERR, tit_pkg::RSN_THERM};
    tit_pkg::tit_int_t wcode[4] = '{tit_pkg::INT_EXT, tit_pkg::INT_DEC,
                                    tit_pkg::INT_SYSERR, tit_pkg::INT_THERM};

    always #5 mclk_i = ~mclk_i;

    tit_thread_model thr (.mclk_i, .sys_rst_i, .resume_i(resume_o), .ld_i(ld),
        .en_i(en_in), .hs_i(hs_in), .en_o(en), .hs_o(hs));

    // Privilege bits only matter while the CF_HSRR config bit is set
    tit_core uut (.mclk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .fp_exc_mode_0_i(fp0), .fp_exc_mode_1_i(fp1),
        .external_enable_i(en), .hypervisor_state_i(hs),
        .user_privilege_state_i(2'h0), .supervisor_bit_i(2'h0),
        .mc_enable_i(mce), .exc_valid_i, .exc_thread_i, .exc_kind_i,
        .mc_int_i, .dec_int_i, .hdec_int_i, .suspend_i, .exec_busy_i,
        .ext_int_pin_i, .sys_mc_pin_i, .therm_pin_i, .trace_sig_pin_i,
        .thread_active_o, .resume_o, .int_req_o, .int_code0_o, .int_code1_o,
        .reason0_o, .reason1_o, .prio0_o, .prio1_o, .single_issue_o,
        .issue_hold_o, .irq_o);

    // ************************************************
    // Shared tasks
    // ************************************************
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : cyc
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i) {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
        @(posedge mclk_i) wr_i <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk_i) {rd_i, addr_i} <= {1'b1, a};
        @(posedge mclk_i) rd_i <= 1'b0;
        #1 chk(rdata_o, exp);
    endtask : rd
    task machine_state_reg(input int th, input logic e, input logic h);
        @(posedge mclk_i) {ld[th], en_in[th], hs_in[th]} <= {1'b1, e, h};
        @(posedge mclk_i) ld[th] <= 1'b0;
    endtask : machine_state_reg
    task suspend(input int th);
        @(posedge mclk_i) suspend_i[th] <= 1'b1;
        @(posedge mclk_i) suspend_i[th] <= 1'b0;
        m_act[th] = 0;
        cyc(2);
    endtask : suspend
    task wait_res(input int th, input int rsn);
        int i;
        i = 0;
        #1;
        while (resume_o[th] !== 1'b1 && i < 10) begin
            cyc(1);
            i++;
        end
        chk(resume_o[th], 1'b1);
        m_act[th] = 1;
        m_rsn[th] = rsn;
        m_prio[th] = tit_pkg::PRIO_HIGH;
    endtask : wait_res
    task state;
        chk(thread_active_o, {m_act[1][0], m_act[0][0]});
        chk(reason0_o, m_rsn[0]);
        chk(reason1_o, m_rsn[1]);
        chk(prio0_o, m_prio[0]);
        chk(prio1_o, m_prio[1]);
    endtask : state
    task set_src(input int s, input logic v);
        case (s)
            0: ext_int_pin_i <= v;
            1: dec_int_i[1] <= v;
            2: sys_mc_pin_i <= v;
            default: therm_pin_i <= v;
        endcase
    endtask : set_src
    task end_test(input string name);
        $display("Test %0s finished", name);
    endtask : end_test
    task stop_test;
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test

    initial begin
        #200000;
        n_mismatch++;
        stop_test;
    end

    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        {wr_i, rd_i, addr_i, wdata_i, fp0, fp1, mce, dec_int_i} = '0;
        {suspend_i, ld, en_in, hs_in, exc_valid_i, exc_thread_i} = '0;
        {mc_int_i, hdec_int_i, exec_busy_i, ext_int_pin_i} = '0;
        {sys_mc_pin_i, therm_pin_i, trace_sig_pin_i} = '0;
        exc_kind_i = tit_pkg::INT_NONE;
        m_act = '{1, 0};
        m_rsn = '{tit_pkg::RSN_SYSRST, 0};
        m_prio = '{tit_pkg::PRIO_RST, tit_pkg::PRIO_RST};
        repeat (5) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        cyc(1);
        state;
        rd(tit_pkg::OFF_RUN, 32'h1);
        rd(8'h40, 32'h0);
        end_test("reset");
        wr(tit_pkg::OFF_RUN, 32'h2);
        wait_res(1, tit_pkg::RSN_SYSRST);
        state;
        rd(tit_pkg::OFF_REASON, 32'h2d);
        rd(tit_pkg::OFF_STAT, 32'h2);
        wr(tit_pkg::OFF_MASK, 32'h2);
        cyc(1);
        chk(irq_o, 1'b1);
        wr(tit_pkg::OFF_STAT, 32'h2);
        cyc(1);
        chk(irq_o, 1'b0);
        r = $random(seed) & 32'hf;
        wr(tit_pkg::OFF_PRIO, r);
        rd(tit_pkg::OFF_PRIO, r);
        m_prio = '{r & 3, r >> 2};
        end_test("software resume");
        for (int k = 1; k <= 11; k++) begin
            t = $random(seed) & 1;
            @(posedge mclk_i) {exc_valid_i, exc_thread_i} <= {1'b1, t[0]};
            exc_kind_i <= tit_pkg::tit_int_t'(k);
            @(posedge mclk_i) exc_valid_i <= 1'b0;
            #1 chk(int_req_o, 2'h1 << t);
            chk(t ? int_code1_o : int_code0_o, k);
        end
        suspend(1);
        @(posedge mclk_i) {exc_valid_i, exc_thread_i} <= 2'h3;
        @(posedge mclk_i) exc_valid_i <= 1'b0;
        cyc(3);
        chk(int_req_o[1], 1'b0);
        state;
        end_test("thread exceptions");
        for (int i = 0; i < 4; i++) begin
            {fp1, fp0} <= 4'h1 << i;
            cyc(2);
            for (int j = 0; j < 6; j++) begin
                @(posedge mclk_i) exec_busy_i <= $random(seed);
                #1 chk(single_issue_o, 1'b1);
                chk(issue_hold_o, {2{exec_busy_i}});
            end
            {fp1, fp0} <= 4'h0;
            cyc(2);
            chk(single_issue_o, 1'b0);
        end
        chk(irq_o, 1'b0);
        wr(tit_pkg::OFF_MASK, 32'h4);
        cyc(1);
        chk(irq_o, 1'b1);
        wr(tit_pkg::OFF_STAT, 32'h4);
        cyc(1);
        chk(irq_o, 1'b0);
        end_test("single issue");
        wr(tit_pkg::OFF_CFG, 32'h82);
        for (int s = 0; s < 4; s++) begin
            set_src(s, 1'b1);
            cyc(8);
            chk(thread_active_o[1], 1'b0);
            wr(tit_pkg::OFF_WAKE, 32'h1 << wbit[s]);
            wait_res(1, wrsn[s]);
            state;
            cyc(2);
            chk(int_req_o[1], 1'b0);
            wr(tit_pkg::OFF_CFG, 32'h86);
            machine_state_reg(1, 1'b1, 1'b0);
            cyc(2);
            chk(int_req_o[1], 1'b1);
            chk(int_code1_o, wcode[s]);
            set_src(s, 1'b0);
            wr(tit_pkg::OFF_WAKE, 32'h0);
            wr(tit_pkg::OFF_CFG, 32'h82);
            machine_state_reg(1, 1'b0, 1'b1);
            suspend(1);
            state;
        end
        end_test("wake sources");
        wr(tit_pkg::OFF_WAKE, 32'h1f);
        mce <= 2'h2;
        mc_int_i <= 1'b1;
        cyc(3);
        chk(int_req_o[0], 1'b0);
        mce <= 2'h3;
        cyc(3);
        chk(int_code0_o, tit_pkg::INT_MC);
        chk(thread_active_o, 2'h1);
        mc_int_i <= 1'b0;
        machine_state_reg(0, 1'b1, 1'b0);
        hdec_int_i <= 1'b1;
        cyc(3);
        chk(int_code0_o, tit_pkg::INT_HDEC);
        chk(thread_active_o, 2'h1);
        hdec_int_i <= 1'b0;
        trace_sig_pin_i <= 1'b1;
        cyc(8);
        chk(int_req_o[0], 1'b1);
        chk(int_code0_o, tit_pkg::INT_MAINT_S);
        end_test("shared interrupts");
        stop_test;
    end
endmodule : tb
